// >>> rtl/fpepc_defines.vh
`ifndef FPEPC_DEFINES_VH
`define FPEPC_DEFINES_VH
// register word addresses
`define FPEPC_A_ADDR 4'h0
`define FPEPC_A_DATA 4'h1
`define FPEPC_A_CMD 4'h2
`define FPEPC_A_STAT 4'h3
`define FPEPC_A_RIS 4'h4
`define FPEPC_A_IEN 4'h5
`define FPEPC_A_MIS 4'h6
`define FPEPC_A_ICLR 4'h7
`define FPEPC_A_PROT 4'h8
`define FPEPC_A_PSEL 4'h9
`define FPEPC_A_COMMIT 4'ha
`define FPEPC_A_RDATA 4'hb
// command register bits
`define FPEPC_CMD_PROG 0
`define FPEPC_CMD_ERASE 1
`define FPEPC_CMD_READ 2
`define FPEPC_CMD_FETCH 3
// interrupt source bits
`define FPEPC_INT_ACCESS 0
`define FPEPC_INT_DONE 1
`define FPEPC_INT_STORE 2
`define FPEPC_INT_VOLT 3
`define FPEPC_INT_DATA 4
`define FPEPC_INT_ERASE 5
`define FPEPC_INT_PROG 6
`define FPEPC_NINT 7
// protection codes
`define FPEPC_PROT_RW 2'h0
`define FPEPC_PROT_RO 2'h1
`define FPEPC_PROT_XO 2'h2
// array timing
`define FPEPC_T_PROG_NS 20000
`define FPEPC_T_ERASE_NS 1000000
`define FPEPC_CLK_NS 50
`define FPEPC_ERASED_BYTE 8'hff
`endif

// >>> rtl/fpepc_ctrl.v
// How it works
// - erase writes all ones into every word of the block
// - erase or program of a read-only block is refused, contents kept
// - execute-only blocks refuse writes; only instruction fetches may read them
// - each program writes one aligned word
// - programming only clears bits; repeat programs allowed if clearing only
// - block size is a parameter; erase touches exactly one block
// - writes to read-only or execute-only blocks set the access flag
// - completion of program or erase sets the done flag
// - data-store events set the forwarded flag; cause read externally
// - supply out of range aborts the operation and sets voltage flag
// - program needing a zero to become one sets the data flag
// - erase not completing sets the erase-failure flag
// - program not completing sets the program-failure flag
// - software clears any subset of flags by writing a mask
// - per-source enables gate flags onto the interrupt line
// - invalid reads of execute-only blocks also raise the access flag
// - protection writes act at once, without commit
// - controller times program and erase itself
// - status readable raw or masked
// - protection may only tighten; loosening is blocked
// - uncommitted protection reverts to committed values on reset
// - commit is permanent, surviving reset
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpepc_defines.vh"
module fpepc_ctrl #(
  parameter AW = 10,
  parameter BLK_WORDS = 256,
  parameter NBLK = 4,
  parameter ERASE_CYC = `FPEPC_T_ERASE_NS / `FPEPC_CLK_NS,
  parameter PROG_CYC = (`FPEPC_T_PROG_NS + `FPEPC_CLK_NS - 1) / `FPEPC_CLK_NS
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // register port
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // events from outside
  input wire i_store_event,
  input wire i_volt_bad,
  // status
  output wire o_busy,
  output wire o_irq
);
  localparam BW = $clog2(NBLK);
  localparam OW = $clog2(BLK_WORDS);
  localparam S_IDLE = 3'b001;
  localparam S_PROG = 3'b010;
  localparam S_ERASE = 3'b100;

  reg [31:0] mem [0:(1<<AW)-1];
  reg [1:0] prot [0:NBLK-1];
  reg [1:0] commit_prot [0:NBLK-1];
  reg [AW-1:0] addr;
  reg [31:0] data;
  reg [31:0] rdata;
  reg [2:0] state;
  reg [31:0] cnt;
  reg [OW-1:0] eidx;
  reg [`FPEPC_NINT-1:0] ris;
  reg [`FPEPC_NINT-1:0] ien;
  reg [`FPEPC_NINT-1:0] ev;
  reg [BW-1:0] psel;
  reg [2:0] store_s;
  reg store_d;
  reg [2:0] volt_s;
  reg volt_ok_q;
  integer k;

  wire [BW-1:0] blk = addr[AW-1:OW];
  wire [1:0] bprot = prot[blk];
  wire idle = state[0];
  wire wr_cmd = i_wr && (i_addr == `FPEPC_A_CMD);
  // store level counts once stages two and three agree
  wire store_ok = (store_s[1] == store_s[2]) ? store_s[2] : store_d;
  // volt level counts once stages two and three agree
  wire volt_bad = (volt_s[1] == volt_s[2]) ? volt_s[2] : volt_ok_q;

  assign o_busy = !idle;
  assign o_irq = |(ris & ien);

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      store_s <= 3'h0;
      store_d <= 1'b0;
      volt_s <= 3'h0;
      volt_ok_q <= 1'b0;
    end else begin
      store_s <= {store_s[1:0], i_store_event};
      store_d <= store_ok;
      volt_s <= {volt_s[1:0], i_volt_bad};
      volt_ok_q <= volt_bad;
    end
  end

  always @* begin
    ev = {`FPEPC_NINT{1'b0}};
    ev[`FPEPC_INT_STORE] = store_ok && !store_d;
    if (wr_cmd && idle) begin
      if ((i_wdata[`FPEPC_CMD_PROG] || i_wdata[`FPEPC_CMD_ERASE]) &&
          bprot != `FPEPC_PROT_RW)
        ev[`FPEPC_INT_ACCESS] = 1'b1;
      if (i_wdata[`FPEPC_CMD_READ] && bprot == `FPEPC_PROT_XO)
        ev[`FPEPC_INT_ACCESS] = 1'b1;
      if (i_wdata[`FPEPC_CMD_PROG] && bprot == `FPEPC_PROT_RW && |(data & ~mem[addr]))
        ev[`FPEPC_INT_DATA] = 1'b1;
    end
    if (!idle && volt_bad) begin
      ev[`FPEPC_INT_VOLT] = 1'b1;
      ev[`FPEPC_INT_ERASE] = state[2];
      ev[`FPEPC_INT_PROG] = state[1];
    end else if (!idle && cnt == 32'h0 && (state[1] || eidx == {OW{1'b1}})) begin
      ev[`FPEPC_INT_DONE] = 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= S_IDLE;
      cnt <= 32'h0;
      eidx <= {OW{1'b0}};
      addr <= {AW{1'b0}};
      data <= 32'h0;
      rdata <= 32'h0;
      ris <= {`FPEPC_NINT{1'b0}};
      ien <= {`FPEPC_NINT{1'b0}};
      psel <= {BW{1'b0}};
    end else begin
      ris <= (ris & ~((i_wr && i_addr == `FPEPC_A_ICLR) ? i_wdata[`FPEPC_NINT-1:0] :
        {`FPEPC_NINT{1'b0}})) | ev;
      if (i_wr && i_addr == `FPEPC_A_IEN)
        ien <= i_wdata[`FPEPC_NINT-1:0];
      if (i_wr && i_addr == `FPEPC_A_PSEL)
        psel <= i_wdata[BW-1:0];
      if (idle && i_wr && i_addr == `FPEPC_A_ADDR)
        addr <= i_wdata[AW-1:0];
      if (idle && i_wr && i_addr == `FPEPC_A_DATA)
        data <= i_wdata;
      case (state)
        S_IDLE: begin
          if (wr_cmd && bprot == `FPEPC_PROT_RW && !ev[`FPEPC_INT_DATA]) begin
            if (i_wdata[`FPEPC_CMD_ERASE]) begin
              state <= S_ERASE;
              eidx <= {OW{1'b0}};
              // each word takes ERASE_CYC / BLK_WORDS cycles, rounded down, so the block takes at most ERASE_CYC
              cnt <= ERASE_CYC / BLK_WORDS - 1;
            end else if (i_wdata[`FPEPC_CMD_PROG]) begin
              state <= S_PROG;
              cnt <= PROG_CYC - 1;
            end
          end
          // fetch may read execute-only, data read may not
          if (wr_cmd && (i_wdata[`FPEPC_CMD_FETCH] ||
              (i_wdata[`FPEPC_CMD_READ] && bprot != `FPEPC_PROT_XO)))
            rdata <= mem[addr];
        end
        S_PROG: begin
          if (volt_bad)
            state <= S_IDLE;
          else if (cnt == 32'h0)
            state <= S_IDLE;
          else
            cnt <= cnt - 32'h1;
        end
        S_ERASE: begin
          if (volt_bad) begin
            state <= S_IDLE;
          end else if (cnt == 32'h0) begin
            eidx <= eidx + {{(OW-1){1'b0}}, 1'b1};
            cnt <= ERASE_CYC / BLK_WORDS - 1;
            if (eidx == {OW{1'b1}})
              state <= S_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // array itself has no reset
  always @(posedge i_clk_sys) begin
    // one aligned word; AND only clears bits
    if (state[1] && cnt == 32'h0 && !volt_bad)
      mem[addr] <= mem[addr] & data;
    if (state[2] && cnt == 32'h0 && !volt_bad)
      mem[{blk, eidx}] <= {4{`FPEPC_ERASED_BYTE}};
  end

  // protection: committed copy is modelled as never reset
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < NBLK; k = k + 1)
        prot[k] <= `FPEPC_PROT_RW;
    end else begin
      for (k = 0; k < NBLK; k = k + 1)
        if (prot[k] == `FPEPC_PROT_RW && commit_prot[k] != `FPEPC_PROT_RW &&
            (commit_prot[k] == `FPEPC_PROT_RO || commit_prot[k] == `FPEPC_PROT_XO))
          prot[k] <= commit_prot[k];
      // immediate; tighten only, and read-only path
      if (i_wr && i_addr == `FPEPC_A_PROT &&
          ((prot[psel] == `FPEPC_PROT_RW && i_wdata[1:0] != 2'h3) ||
           (prot[psel] == `FPEPC_PROT_RO && i_wdata[1:0] == `FPEPC_PROT_XO)))
        prot[psel] <= i_wdata[1:0];
    end
  end

  // committed copy has no reset path
  initial begin
    for (k = 0; k < NBLK; k = k + 1)
      commit_prot[k] = `FPEPC_PROT_RW;
  end
  always @(posedge i_clk_sys) begin
    if (i_wr && i_addr == `FPEPC_A_COMMIT && i_wdata[0])
      for (k = 0; k < NBLK; k = k + 1)
        if (prot[k] != `FPEPC_PROT_RW)
          commit_prot[k] <= prot[k];
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `FPEPC_A_ADDR: o_rdata <= {{(32-AW){1'b0}}, addr};
        `FPEPC_A_DATA: o_rdata <= data;
        `FPEPC_A_STAT: o_rdata <= {31'h0, !idle};
        `FPEPC_A_RIS: o_rdata <= {{(32-`FPEPC_NINT){1'b0}}, ris};
        `FPEPC_A_IEN: o_rdata <= {{(32-`FPEPC_NINT){1'b0}}, ien};
        `FPEPC_A_MIS: o_rdata <= {{(32-`FPEPC_NINT){1'b0}}, ris & ien};
        `FPEPC_A_PROT: o_rdata <= {30'h0, prot[psel]};
        `FPEPC_A_PSEL: o_rdata <= {{(32-BW){1'b0}}, psel};
        `FPEPC_A_RDATA: o_rdata <= rdata;
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end
endmodule // fpepc_ctrl
`default_nettype wire

// >>> tb/fpepc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpepc_defines.vh"
module fpepc_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // events and status
  input wire logic i_store_event,
  input wire logic i_volt_bad,
  input wire logic o_busy,
  input wire logic o_irq
);
  logic [6:0] en;
  logic [3:0] ev;
  // shadow of enables; recent event history
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en <= 7'h0;
      ev <= 4'h0;
    end else begin
      if (i_wr && i_addr == `FPEPC_A_IEN) en <= i_wdata[6:0];
      ev <= {ev[2:0], i_store_event};
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_cmd;
    i_wr && i_addr == `FPEPC_A_CMD;
  endsequence
  sequence s_clr;
    i_wr && i_addr == `FPEPC_A_ICLR && i_wdata[6:0] == 7'h7f;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_BUSY_CAUSE: assert property ($rose(o_busy) |-> $past(i_wr && i_addr == `FPEPC_A_CMD))
    else $error("busy rose without a command");
  AST_BUSY_END: assert property (s_cmd ##1 $rose(o_busy) |-> ##[1:600] !o_busy)
    else $error("operation never ended");
  AST_IRQ_OFF: assert property (en == 7'h0 |-> !o_irq)
    else $error("interrupt with all sources disabled");
  AST_MIS: assert property ($past(i_rd && i_addr == `FPEPC_A_MIS) |-> (o_rdata != 32'h0) == $past(o_irq))
    else $error("masked status disagrees with interrupt line");
  AST_STAT: assert property ($past(i_rd && i_addr == `FPEPC_A_STAT) |-> o_rdata[0] == $past(o_busy))
    else $error("status busy bit wrong");
  AST_VOLT: assert property ((o_busy && i_volt_bad) [*2] |-> ##[1:6] !o_busy)
    else $error("operation not aborted on bad supply");
  AST_CLR: assert property (s_clr and (!o_busy && !$past(o_busy) && !$past(i_wr) && ev == 4'h0 && !i_store_event) |-> ##2 !o_irq)
    else $error("interrupt still high after full clear");
endmodule // fpepc_chk
bind fpepc_ctrl fpepc_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_store_event(i_store_event),
  .i_volt_bad(i_volt_bad), .o_busy(o_busy), .o_irq(o_irq));
`default_nettype wire

// >>> tb/fpepc_far.sv
`timescale 1ns/1ps
`default_nettype none
module fpepc_far (
  // requests from the bench
  input wire logic i_clk_sys,
  input wire logic i_store_go,
  input wire logic i_volt_go,
  // event lines
  output logic o_store_event,
  output logic o_volt_bad
);
  logic [1:0] hold = 2'h0;
  always @(posedge i_clk_sys) begin
    if (i_store_go) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
    o_store_event <= i_store_go || hold != 2'h0;
    o_volt_bad <= i_volt_go;
  end
endmodule // fpepc_far
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpepc_defines.vh"
module tb_top;
  localparam [31:0] AC = 32'h1 << `FPEPC_INT_ACCESS;
  localparam [31:0] DN = 32'h1 << `FPEPC_INT_DONE;
  localparam [31:0] ST = 32'h1 << `FPEPC_INT_STORE;
  localparam [31:0] VO = 32'h1 << `FPEPC_INT_VOLT;
  localparam [31:0] DT = 32'h1 << `FPEPC_INT_DATA;
  localparam [31:0] ER = 32'h1 << `FPEPC_INT_ERASE;
  localparam [31:0] PG = 32'h1 << `FPEPC_INT_PROG;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic store_go = 1'b0;
  logic volt_go = 1'b0;
  logic [31:0] m, v, got;
  wire [31:0] o_rdata;
  wire store_ev, volt_bad, o_busy, o_irq;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 6936;
  always #25 i_clk_sys = ~i_clk_sys;
  fpepc_far i_far (.i_clk_sys(i_clk_sys), .i_store_go(store_go), .i_volt_go(volt_go),
    .o_store_event(store_ev), .o_volt_bad(volt_bad));
  fpepc_ctrl #(.ERASE_CYC(512), .PROG_CYC(4)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_store_event(store_ev), .i_volt_bad(volt_bad), .o_busy(o_busy), .o_irq(o_irq));
  task end_of_test;
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    got = o_rdata;
  endtask
  task fl(input string n, input [31:0] e);
    rd(`FPEPC_A_RIS);
    chk(n, got, e);
    wr(`FPEPC_A_ICLR, 32'h7f);
  endtask
  task rdw(input [31:0] a);
    wr(`FPEPC_A_ADDR, a);
    wr(`FPEPC_A_CMD, 32'h4);
    rd(`FPEPC_A_RDATA);
  endtask
  // bad supply rises just after data, so it lands mid-operation
  task op(input [31:0] a, input [3:0] c, input [31:0] d, input b);
    wr(`FPEPC_A_ADDR, a);
    wr(`FPEPC_A_DATA, d);
    volt_go <= b;
    wr(`FPEPC_A_CMD, {28'h0, c});
    if (a == 0 && c == 4'h2 && !b) begin
      rd(`FPEPC_A_STAT);
      chk("busy", got, 32'h1);
      wr(`FPEPC_A_CMD, 32'h1);
    end
    @(negedge i_clk_sys);
    repeat (700) if (o_busy) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    volt_go <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    op(0, 2, 0, 0);
    fl("erase", DN);
    rdw(0);
    chk("erased", got, 32'hffffffff);
    m = $random(seed) & 32'hfffffffe;
    op(5, 1, m, 0);
    fl("prog", DN);
    v = m & $random(seed);
    op(5, 1, v, 0);
    fl("reprog", DN);
    op(5, 1, v | 32'h1, 0);
    fl("up bit", DT);
    rdw(5);
    chk("word", got, v);
    rdw(4);
    chk("next", got, 32'hffffffff);
    wr(`FPEPC_A_PSEL, 1);
    wr(`FPEPC_A_PROT, 1);
    wr(`FPEPC_A_PROT, 0);
    op(256, 2, 0, 0);
    fl("ro", AC);
    wr(`FPEPC_A_PSEL, 2);
    wr(`FPEPC_A_PROT, 2);
    op(512, 1, 0, 0);
    fl("xo", AC);
    rdw(512);
    fl("xo rd", AC);
    op(512, 8, 0, 0);
    fl("fetch", 0);
    store_go <= 1'b1;
    @(posedge i_clk_sys);
    store_go <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    wr(`FPEPC_A_IEN, ST);
    @(negedge i_clk_sys);
    chk("irq", {31'h0, o_irq}, 1);
    rd(`FPEPC_A_MIS);
    chk("mis", got, ST);
    wr(`FPEPC_A_ICLR, ST);
    repeat (2) @(negedge i_clk_sys);
    chk("irq clr", {31'h0, o_irq}, 0);
    wr(`FPEPC_A_IEN, 0);
    op(0, 2, 0, 1);
    fl("v erase", VO | ER);
    op(6, 1, 0, 1);
    fl("v prog", VO | PG);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    op(256, 2, 0, 0);
    fl("reset", DN);
    wr(`FPEPC_A_PSEL, 3);
    wr(`FPEPC_A_PROT, 1);
    wr(`FPEPC_A_COMMIT, 1);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    op(768, 2, 0, 0);
    fl("commit", AC);
    end_of_test;
  end
  initial begin
    #1000000;
    err_total++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
